// [core/uefc_consts.vh]
// constants for the enhanced flow-control block of one uart channel
`ifndef UEFC_CONSTS_VH
`define UEFC_CONSTS_VH

// ==========================================================
// register indices (byte address = 4 * index)
`define UEFC_IDX_FEAT     6'h0A
`define UEFC_IDX_RES_A    6'h0B
`define UEFC_IDX_RES_B    6'h0C
`define UEFC_IDX_STOP_A   6'h0D
`define UEFC_IDX_STOP_B   6'h0E
`define UEFC_IDX_RFS      6'h0F
`define UEFC_IDX_TTL      6'h10
`define UEFC_IDX_FCL      6'h12
`define UEFC_IDX_FCH      6'h13
`define UEFC_IDX_FILL     6'h15
`define UEFC_IDX_ISR      6'h20
`define UEFC_IDX_IMR      6'h21

// ==========================================================
// enhanced_feature_ctrl fields
`define UEFC_FEAT_RXM_LO  0
`define UEFC_FEAT_TXM_LO  2
`define UEFC_FEAT_ENH     4
`define UEFC_FEAT_SCD     5
`define UEFC_FEAT_ARTS    6
`define UEFC_FEAT_ACTS    7

// flow-control mode codes (both two-bit fields)
`define UEFC_FC_OFF       2'h0
`define UEFC_FC_SET_B     2'h1
`define UEFC_FC_SET_A     2'h2
`define UEFC_FC_BOTH      2'h3

// ==========================================================
// remote_flow_status fields
`define UEFC_RFS_TERM     0
`define UEFC_RFS_RDIS     1
`define UEFC_RFS_XDET     2
`define UEFC_RFS_SDET     3

// interrupt status / mask fields
`define UEFC_IRQ_CHAR     0
`define UEFC_IRQ_TX       1
`define UEFC_IRQ_W        2

// ==========================================================
// reset values and rx fill-level maximum
`define UEFC_RST_BYTE     8'h00
`define UEFC_RST_IRQ      2'h0
`define UEFC_FILL_MAX     8'hFF

`endif

// [core/uefc_core.v]
// enhanced flow control of one uart channel with an apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "uefc_consts.vh"

// Summary of operation
// (R01) tx in-band on: send stop above high level, resume below low level
// (R02) software sets enhanced mode before automatic tx in-band control works
// (R03) tx mode 00 off, 01 uses set b, 10 uses set a, 11 reserved
// (R04) enhanced-mode bit resets to zero; one enables enhanced functions
// (R05) special detection compares received chars with both stop characters
// (R06) software enables special detection whenever in-band control is on
// (R07) auto rts in enhanced mode drives rts_n high at high threshold
// (R08) forced-high rts_n released once fill drops below low threshold
// (R09) auto cts in enhanced mode holds data while cts_n is high
// (R10) status bit shows transmitter held off by remote terminate
// (R11) status bit shows stop or rts message has been sent
// (R12) resume/stop received sets a status bit cleared by reading
// (R13) special character detected sets a status bit cleared by reading
// (R14) detect status also raises the priority six interrupt source
// (R15) eight-bit tx interrupt trigger level, reset zero, sets tx interrupt
// (R16) upper four bits of remote_flow_status read zero
// (R17) received stop halts after current char; matching resume restarts
// (R18) low and high thresholds are eight-bit registers resetting zero
// (R19) rx fill level counts characters written and read in rx fifo
module uefc_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        rx_valid,
  input  wire [7:0]  rx_char,
  input  wire        rx_pop,
  input  wire        src_valid,
  input  wire [7:0]  src_data,
  output wire        src_ready,
  output reg         tx_valid,
  output reg  [7:0]  tx_char,
  input  wire        tx_ready,
  input  wire [7:0]  tx_level,
  input  wire        modem_rts_on,
  input  wire        cts_n,
  output reg         rts_n,
  output wire        irq
);

  // ========================================================
  // registers
  reg  [7:0] enhanced_feature_ctrl, resume_char_a, resume_char_b;
  reg  [7:0] stop_char_a, stop_char_b, tx_irq_threshold;
  reg  [7:0] flow_low, flow_high, rx_fill_level;
  reg  [`UEFC_IRQ_W-1:0] irq_status, irq_mask;

  // flow state
  reg        stop_sent, rts_forced, rx_halt, xdet, sdet;
  reg        cts_s1, cts_s2, tx_low_d;

  // ========================================================
  // field views
  wire       enh, scd_en, arts_en, acts_en;
  wire [1:0] rx_mode, tx_mode;

  assign enh     = enhanced_feature_ctrl[`UEFC_FEAT_ENH]; // R04
  assign rx_mode = enhanced_feature_ctrl[`UEFC_FEAT_RXM_LO+1:`UEFC_FEAT_RXM_LO];
  assign tx_mode = enhanced_feature_ctrl[`UEFC_FEAT_TXM_LO+1:`UEFC_FEAT_TXM_LO];
  assign scd_en  = enhanced_feature_ctrl[`UEFC_FEAT_SCD];
  assign arts_en = enhanced_feature_ctrl[`UEFC_FEAT_ARTS] & enh;
  assign acts_en = enhanced_feature_ctrl[`UEFC_FEAT_ACTS] & enh;

  // ========================================================
  // apb decode
  wire [5:0] idx;
  wire       acc, wr, rd, setup_rd;
  reg        mapped;

  assign idx      = paddr[7:2];
  assign acc      = psel & penable;
  assign wr       = acc & pwrite & mapped;
  assign rd       = acc & ~pwrite & mapped;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;

  always @* begin
    case (idx)
      `UEFC_IDX_FEAT,
      `UEFC_IDX_RES_A,
      `UEFC_IDX_RES_B,
      `UEFC_IDX_STOP_A,
      `UEFC_IDX_STOP_B,
      `UEFC_IDX_RFS,
      `UEFC_IDX_TTL,
      `UEFC_IDX_FCL,
      `UEFC_IDX_FCH,
      `UEFC_IDX_FILL,
      `UEFC_IDX_ISR,
      `UEFC_IDX_IMR: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
  end

  // ========================================================
  // status view and read mux
  wire       cts_hold;
  wire [7:0] rfs_view;
  reg  [7:0] next_rd;

  // cts_s2 high means the peer deasserts clear-to-send
  assign cts_hold = acts_en & cts_s2; // R09

  assign rfs_view = {4'h0, // R16
                     sdet,
                     xdet,
                     stop_sent | rts_forced, // R11
                     rx_halt | cts_hold}; // R10

  always @* begin
    case (idx)
      `UEFC_IDX_FEAT:   next_rd = enhanced_feature_ctrl;
      `UEFC_IDX_RES_A:  next_rd = resume_char_a;
      `UEFC_IDX_RES_B:  next_rd = resume_char_b;
      `UEFC_IDX_STOP_A: next_rd = stop_char_a;
      `UEFC_IDX_STOP_B: next_rd = stop_char_b;
      `UEFC_IDX_RFS:    next_rd = rfs_view;
      `UEFC_IDX_TTL:    next_rd = tx_irq_threshold;
      `UEFC_IDX_FCL:    next_rd = flow_low;
      `UEFC_IDX_FCH:    next_rd = flow_high;
      `UEFC_IDX_FILL:   next_rd = rx_fill_level;
      `UEFC_IDX_ISR:    next_rd = {6'h00, irq_status};
      `UEFC_IDX_IMR:    next_rd = {6'h00, irq_mask};
      default:          next_rd = 8'h00;
    endcase
  end

  // read data is captured in the setup cycle; the read-clear
  // later only drops bits that this capture actually saw
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= {24'h00_0000, next_rd};
    end
  end

  wire rfs_rd, xdet_clr, sdet_clr;

  assign rfs_rd   = rd & (idx == `UEFC_IDX_RFS);
  assign xdet_clr = rfs_rd & prdata[`UEFC_RFS_XDET];
  assign sdet_clr = rfs_rd & prdata[`UEFC_RFS_SDET];

  // ========================================================
  // writable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enhanced_feature_ctrl <= `UEFC_RST_BYTE; // R04
      resume_char_a         <= `UEFC_RST_BYTE;
      resume_char_b         <= `UEFC_RST_BYTE;
      stop_char_a           <= `UEFC_RST_BYTE;
      stop_char_b           <= `UEFC_RST_BYTE;
      tx_irq_threshold      <= `UEFC_RST_BYTE; // R15
      flow_low              <= `UEFC_RST_BYTE; // R18
      flow_high             <= `UEFC_RST_BYTE; // R18
      irq_mask              <= `UEFC_RST_IRQ;
    end else if (wr) begin
      case (idx)
        `UEFC_IDX_FEAT:   enhanced_feature_ctrl <= pwdata[7:0];
        `UEFC_IDX_RES_A:  resume_char_a <= pwdata[7:0];
        `UEFC_IDX_RES_B:  resume_char_b <= pwdata[7:0];
        `UEFC_IDX_STOP_A: stop_char_a <= pwdata[7:0];
        `UEFC_IDX_STOP_B: stop_char_b <= pwdata[7:0];
        `UEFC_IDX_TTL:    tx_irq_threshold <= pwdata[7:0]; // R15
        `UEFC_IDX_FCL:    flow_low <= pwdata[7:0]; // R18
        `UEFC_IDX_FCH:    flow_high <= pwdata[7:0]; // R18
        `UEFC_IDX_IMR:    irq_mask <= pwdata[`UEFC_IRQ_W-1:0];
        default:          irq_mask <= irq_mask;
      endcase
    end
  end

  // ========================================================
  // rx fill level
  wire push, pop;

  assign push = rx_valid & (rx_fill_level != `UEFC_FILL_MAX);
  assign pop  = rx_pop & (rx_fill_level != 8'h00);

  // a push and a pop in the same cycle cancel out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fill_level <= `UEFC_RST_BYTE;
    end else if (push & ~pop) begin
      rx_fill_level <= rx_fill_level + 8'h01; // R19
    end else if (pop & ~push) begin
      rx_fill_level <= rx_fill_level - 8'h01; // R19
    end
  end

  wire above_high, at_high, below_low;

  assign above_high = rx_fill_level > flow_high;
  assign at_high    = rx_fill_level >= flow_high;
  assign below_low  = rx_fill_level < flow_low;

  // ========================================================
  // received character matching
  wire is_stop_a, is_stop_b, is_res_a, is_res_b;
  reg  stop_hit, res_hit;
  wire spec_hit;

  assign is_stop_a = rx_char == stop_char_a;
  assign is_stop_b = rx_char == stop_char_b;
  assign is_res_a  = rx_char == resume_char_a;
  assign is_res_b  = rx_char == resume_char_b;

  always @* begin
    case (rx_mode)
      `UEFC_FC_SET_B: begin
        stop_hit = is_stop_b;
        res_hit  = is_res_b;
      end
      `UEFC_FC_SET_A: begin
        stop_hit = is_stop_a;
        res_hit  = is_res_a;
      end
      `UEFC_FC_BOTH: begin
        stop_hit = is_stop_a | is_stop_b;
        res_hit  = is_res_a | is_res_b;
      end
      default: begin
        stop_hit = 1'b0;
        res_hit  = 1'b0;
      end
    endcase
  end

  assign spec_hit = rx_valid & enh & scd_en & (is_stop_a | is_stop_b); // R05

  wire xdet_ev;

  assign xdet_ev = rx_valid & (stop_hit | res_hit);

  // ========================================================
  // receive-side state; a new event wins over a read-clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_halt <= 1'b0;
      xdet    <= 1'b0;
      sdet    <= 1'b0;
    end else begin
      if (rx_mode == `UEFC_FC_OFF) begin
        rx_halt <= 1'b0;
      end else if (rx_valid & stop_hit) begin
        rx_halt <= 1'b1; // R17
      end else if (rx_valid & res_hit) begin
        rx_halt <= 1'b0; // R17
      end
      if (xdet_ev) begin
        xdet <= 1'b1; // R12
      end else if (xdet_clr) begin
        xdet <= 1'b0; // R12
      end
      if (spec_hit) begin
        sdet <= 1'b1; // R13
      end else if (sdet_clr) begin
        sdet <= 1'b0; // R13
      end
    end
  end

  // ========================================================
  // cts synchroniser and automatic rts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
    end else begin
      cts_s1 <= cts_n;
      cts_s2 <= cts_s1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_forced <= 1'b0;
    end else if (~arts_en) begin
      rts_forced <= 1'b0;
    end else if (at_high) begin
      rts_forced <= 1'b1; // R07
    end else if (below_low) begin
      rts_forced <= 1'b0; // R08
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= rts_forced | ~modem_rts_on; // R07
    end
  end

  // ========================================================
  // transmit path with in-band character insertion
  wire       tx_fc_on, need_stop, need_resume, load, data_go;
  reg  [7:0] ins_stop, ins_resume;

  // reserved mode 11 is treated as off
  assign tx_fc_on = enh & // R02
                    ((tx_mode == `UEFC_FC_SET_B) |
                     (tx_mode == `UEFC_FC_SET_A)); // R03

  assign need_stop   = tx_fc_on & ~stop_sent & above_high; // R01
  assign need_resume = tx_fc_on & stop_sent & below_low; // R01

  always @* begin
    if (tx_mode == `UEFC_FC_SET_B) begin
      ins_stop   = stop_char_b; // R03
      ins_resume = resume_char_b;
    end else begin
      ins_stop   = stop_char_a; // R03
      ins_resume = resume_char_a;
    end
  end

  // flow characters go ahead of data and ignore the hold-offs,
  // otherwise a halted link could never be told to resume
  assign load      = ~tx_valid | tx_ready;
  assign src_ready = load & ~need_stop & ~need_resume &
                     ~rx_halt & ~cts_hold; // R09
  assign data_go   = src_valid & src_ready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid  <= 1'b0;
      tx_char   <= 8'h00;
      stop_sent <= 1'b0;
    end else begin
      if (load & need_stop) begin
        tx_valid  <= 1'b1;
        tx_char   <= ins_stop; // R01
        stop_sent <= 1'b1; // R11
      end else if (load & need_resume) begin
        tx_valid  <= 1'b1;
        tx_char   <= ins_resume; // R01
        stop_sent <= 1'b0;
      end else begin
        if (~tx_fc_on) begin
          stop_sent <= 1'b0;
        end
        if (data_go) begin
          tx_valid <= 1'b1;
          tx_char  <= src_data;
        end else if (tx_ready) begin
          tx_valid <= 1'b0; // R17
        end
      end
    end
  end

  // ========================================================
  // interrupts: sticky status, write one to clear, mask
  wire                  tx_low;
  wire [`UEFC_IRQ_W-1:0] irq_set;
  wire [`UEFC_IRQ_W-1:0] irq_clr;

  assign tx_low = tx_level <= tx_irq_threshold; // R15

  assign irq_set[`UEFC_IRQ_CHAR] = xdet_ev | spec_hit; // R14
  assign irq_set[`UEFC_IRQ_TX]   = tx_low & ~tx_low_d; // R15
  assign irq_clr = (wr & (idx == `UEFC_IDX_ISR)) ?
                   pwdata[`UEFC_IRQ_W-1:0] : `UEFC_RST_IRQ;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `UEFC_RST_IRQ;
      tx_low_d   <= 1'b0;
    end else begin
      irq_status <= irq_set | (irq_status & ~irq_clr); // R14
      tx_low_d   <= tx_low;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule
`default_nettype wire

// [tb/uefc_core_tb.sv]
// self-checking bench for the enhanced flow-control block
`timescale 1ns/1ps
`default_nettype none
`include "uefc_consts.vh"
module uefc_core_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, rx_char, src_data, tx_char, tx_level;
  logic [31:0] pwdata, prdata, rd;
  logic        rx_valid, rx_pop, src_valid, src_ready, tx_valid;
  logic        tx_ready, modem_rts_on, cts_n, rts_n, irq, slow, hold;
  logic        err, on;
  logic [7:0]  got, got_n, n0, s, pat;
  logic [1:0]  m;
  int          bad_count, total_checks, i;
  logic [5:0]  ix [12] = '{6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h10,
                          6'h12, 6'h13, 6'h21, 6'h0F, 6'h15, 6'h20};
  uefc_core dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_char, .rx_pop,
    .src_valid, .src_data, .src_ready, .tx_valid, .tx_char, .tx_ready,
    .tx_level, .modem_rts_on, .cts_n, .rts_n, .irq);
  uefc_peer peer (.pclk, .presetn, .tx_valid, .tx_char, .slow, .hold,
    .tx_ready, .rx_valid, .rx_char, .cts_n, .got, .got_n);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ==========================================================
  // checking and bus tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic give_up;
    bad_count++;
    finish_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] v, e);
    total_checks++;
    if (v !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // sample the answer mid-cycle, where it stands until the edge
    for (k = 0; k < 20; k++) begin
      @(negedge pclk);
      if (pready === 1'b1) break;
      @(posedge pclk);
    end
    if (k == 20) give_up();
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task automatic pop(input int n);
    @(posedge pclk);
    rx_pop <= 1'b1;
    repeat (n) @(posedge pclk);
    rx_pop <= 1'b0;
  endtask
  task automatic txb(input logic [7:0] b);
    int k;
    @(posedge pclk);
    src_valid <= 1'b1;
    src_data <= b;
    for (k = 0; k < 90; k++) begin
      @(negedge pclk);
      if (src_ready === 1'b1) break;
    end
    if (k == 90) give_up();
    @(posedge pclk);
    src_valid <= 1'b0;
  endtask
  task automatic wait_got(input logic [7:0] n);
    int k;
    for (k = 0; k < 60 && got_n !== n; k++) @(posedge pclk);
    if (k == 60) give_up();
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, rx_pop, src_valid, slow, hold} = 8'h00;
    {paddr, pwdata, src_data} = 48'h0;
    tx_level = 8'h10;
    modem_rts_on = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 12; i++) rdchk(ix[i], 32'h0);
    for (i = 0; i < 9; i++) begin
      pat = 8'hA5 ^ {2'h0, ix[i]};
      apb(1'b1, ix[i], pat);
      rdchk(ix[i], (i == 8) ? {30'h0, pat[1:0]} : {24'h0, pat});
    end
    apb(1'b1, `UEFC_IDX_RFS, 8'hFF);
    rdchk(`UEFC_IDX_RFS, 32'h0);
    rdchk(6'h11, 32'h0);
    chk("slverr", err, 1'b1);
    apb(1'b1, `UEFC_IDX_RES_A, 8'h11);
    apb(1'b1, `UEFC_IDX_RES_B, 8'h91);
    apb(1'b1, `UEFC_IDX_STOP_A, 8'h13);
    apb(1'b1, `UEFC_IDX_STOP_B, 8'h93);
    apb(1'b1, `UEFC_IDX_FCL, 8'h02);
    apb(1'b1, `UEFC_IDX_FCH, 8'h04);
    apb(1'b1, `UEFC_IDX_TTL, 8'h03);
    apb(1'b1, `UEFC_IDX_IMR, 8'h00);
    apb(1'b1, `UEFC_IDX_ISR, 8'h03);
    peer.send(8'h41, 1);
    // every transmit mode code, one pass each
    for (i = 0; i < 4; i++) begin
      m = i[1:0] ^ 2'h2;
      on = (m == 2'h1 || m == 2'h2);
      s = (m == 2'h2) ? 8'h13 : 8'h93;
      slow <= i[0];
      apb(1'b1, 6'h0A, {4'h7, m, 2'h2});
      n0 = got_n;
      peer.send(8'h41, 4);
      repeat (20) @(posedge pclk);
      chk("rts_n", rts_n, 1'b1);
      chk("stops", got_n - n0, on);
      if (on) chk("stop", got, s);
      rdchk(6'h15, 32'h5);
      apb(1'b0, `UEFC_IDX_RFS, 8'h00);
      chk("remote off", rd[1], 1'b1);
      pop(4);
      repeat (20) @(posedge pclk);
      chk("rts_n", rts_n, 1'b0);
      chk("resumes", got_n - n0, {on, 1'b0});
      if (on) chk("resume", got, s - 8'h02);
    end
    peer.send(8'h93, 1);
    repeat (3) @(posedge pclk);
    chk("irq masked", irq, 1'b0);
    rdchk(`UEFC_IDX_ISR, 32'h1);
    apb(1'b1, `UEFC_IDX_ISR, 8'h01);
    apb(1'b1, `UEFC_IDX_IMR, 8'h01);
    peer.send(8'h13, 1);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 1'b1);
    rdchk(`UEFC_IDX_RFS, 32'h0D);
    rdchk(`UEFC_IDX_RFS, 32'h01);
    n0 = got_n;
    fork
      txb(8'h55);
      begin
        repeat (10) @(posedge pclk);
        chk("halted", got_n - n0, 32'h0);
        peer.send(8'h11, 1);
      end
    join
    wait_got(n0 + 8'h01);
    chk("resumed", got, 8'h55);
    rdchk(`UEFC_IDX_RFS, 32'h06);
    pop(3);
    hold <= 1'b1;
    apb(1'b1, 6'h0A, 8'hFA);
    n0 = got_n;
    fork
      txb(8'h66);
      begin
        repeat (10) @(posedge pclk);
        chk("cts held", got_n - n0, 32'h0);
        apb(1'b0, `UEFC_IDX_RFS, 8'h00);
        chk("terminate", rd[0], 1'b1);
        hold <= 1'b0;
      end
    join
    wait_got(n0 + 8'h01);
    chk("cts sent", got, 8'h66);
    apb(1'b1, 6'h0A, 8'h20);
    peer.send(8'h93, 1);
    rdchk(`UEFC_IDX_RFS, 32'h0);
    apb(1'b1, `UEFC_IDX_ISR, 8'h03);
    @(negedge pclk);
    chk("irq clear", irq, 1'b0);
    apb(1'b1, `UEFC_IDX_IMR, 8'h02);
    tx_level <= 8'h02;
    repeat (3) @(posedge pclk);
    chk("tx irq", irq, 1'b1);
    rdchk(`UEFC_IDX_ISR, 32'h2);
    finish_test();
  end
endmodule
`default_nettype wire

// [tb/uefc_monitor.sv]
// assertion checker for the enhanced flow-control block
`timescale 1ns/1ps
`default_nettype none
`include "uefc_consts.vh"
module uefc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_char,
  input wire logic        rx_pop,
  input wire logic        src_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_char,
  input wire logic        tx_ready,
  input wire logic [7:0]  tx_level,
  input wire logic        modem_rts_on,
  input wire logic        cts_n,
  input wire logic        rts_n,
  input wire logic        irq
);
  logic [7:0] feat, hi, lo, stp, thr, fill;
  logic [1:0] msk;
  // ==========================================================
  // shadow copies, updated only by completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat <= 8'h00;
      hi <= 8'h00;
      lo <= 8'h00;
      stp <= 8'h00;
      thr <= 8'h00;
      msk <= 2'h0;
    end else if (psel && penable && pwrite) begin
      case (paddr[7:2])
        6'h0A: feat <= pwdata[7:0];
        `UEFC_IDX_STOP_A: stp <= pwdata[7:0];
        `UEFC_IDX_TTL: thr <= pwdata[7:0];
        `UEFC_IDX_FCL: lo <= pwdata[7:0];
        `UEFC_IDX_FCH: hi <= pwdata[7:0];
        `UEFC_IDX_IMR: msk <= pwdata[1:0];
        default: ;
      endcase
    end
  end
  // bench never pushes and pops in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill <= 8'h00;
    end else if (rx_valid && !rx_pop && fill != 8'hFF) begin
      fill <= fill + 8'h01;
    end else if (rx_pop && !rx_valid && fill != 8'h00) begin
      fill <= fill - 8'h01;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rts_force;
    feat[6] && feat[4] && fill >= hi |-> ##[1:2] rts_n;
  endproperty
  a_rts_force: assert property (p_rts_force)
    else $error("rts_n not forced");
  property p_rts_free;
    (feat[6] && feat[4] && fill < lo && modem_rts_on)[*3] |-> !rts_n;
  endproperty
  a_rts_free: assert property (p_rts_free)
    else $error("rts_n not released");
  property p_cts_hold;
    (feat[7] && feat[4] && cts_n)[*3] |-> !src_ready;
  endproperty
  a_cts_hold: assert property (p_cts_hold)
    else $error("data taken while cts_n high");
  property p_insert;
    $rose(fill > hi) && feat[4] && feat[3:2] == 2'h2
      |-> ##[1:16] (tx_valid && tx_char == stp);
  endproperty
  a_insert: assert property (p_insert)
    else $error("stop char not inserted");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_char);
  endproperty
  a_hold: assert property (p_hold)
    else $error("tx char dropped");
  property p_spec_irq;
    rx_valid && feat[5] && feat[4] && msk[0] && rx_char == stp |=> irq;
  endproperty
  a_spec_irq: assert property (p_spec_irq)
    else $error("special char irq missing");
  property p_tx_irq;
    $rose(tx_level <= thr) && msk[1] |-> ##[1:2] irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("tx level irq missing");
  property p_rfs_top;
    psel && penable && !pwrite && paddr[7:2] == `UEFC_IDX_RFS
      |-> prdata[31:4] == 28'h0;
  endproperty
  a_rfs_top: assert property (p_rfs_top)
    else $error("status upper bits set");
endmodule
bind uefc_core uefc_monitor u_mon (.*);
`default_nettype wire

// [tb/uefc_peer.sv]
// remote serial peer: takes sent chars, sends received ones
`timescale 1ns/1ps
`default_nettype none
module uefc_peer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  input  wire logic       slow,
  input  wire logic       hold,
  output wire logic       tx_ready,
  output var  logic       rx_valid,
  output var  logic [7:0] rx_char,
  output wire logic       cts_n,
  output var  logic [7:0] got,
  output var  logic [7:0] got_n
);
  logic ph;
  // slow peer takes a char only every other cycle
  assign tx_ready = !slow || ph;
  assign cts_n = hold;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 1'b0;
      got <= 8'h00;
      got_n <= 8'h00;
    end else begin
      ph <= !ph;
      if (tx_valid && tx_ready) begin
        got <= tx_char;
        got_n <= got_n + 8'h01;
      end
    end
  end
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end
  task automatic send(input logic [7:0] c, input int n);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_char <= c;
    repeat (n) @(posedge pclk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask
endmodule
`default_nettype wire
